// ===== design/dsf_core.sv
// execute stage: divide init/step datapath, fp double and divide trap decode
// assumes issue logic presents one instruction per valid cycle, sync reset
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "dsf_regs.svh"

// Summary of operation
// - double add decoded raises its own trap
// - trap loads pointers a, b, c
// - double divide decoded raises its own trap
// - double equal compare raises its own trap
// - double greater-equal compare raises own trap
// - double greater compare raises own trap
// - double operands use register and its twin
// - second operand register or zero-extended immediate
// - divide_flag set subtracts, clear adds
// - new flag is not of carry^flag^negative
// - step shifts sum:Q left, flag into bit0
// - init sets divide_flag, negative from operand_b sign
// - init shifts operand_b:Q left, zero inserted
// - signed divide: Q:operand_a over operand_b
// - signed divide raises trap, loads pointers
module dsf_core (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        issue_valid_i,
   input  wire logic [31:0] instr_i,
   input  wire logic [31:0] operand_a_i,
   input  wire logic [31:0] operand_b_i,
   input  wire logic [7:0]  abs_ra_i,
   input  wire logic [7:0]  abs_rb_i,
   input  wire logic [7:0]  abs_rc_i,
   output logic             issue_ready_o,
   output logic             result_valid_o,
   output logic [31:0]      result_o,
   output logic [7:0]       result_reg_o,
   output logic             trap_o,
   output logic [7:0]       trap_vector_o,
   output logic [7:0]       indirect_pointer_a_o,
   output logic [7:0]       indirect_pointer_b_o,
   output logic [7:0]       indirect_pointer_c_o,
   output logic             divide_flag_o,
   output logic             negative_o,
   output logic [31:0]      q_o,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic             irq_o
);
   logic [7:0]             opcode;
   logic [31:0]            src_b;
   logic [32:0]            sum;
   logic                   nxt_df;
   logic [63:0]            shifted;
   logic [7:0]             vec;
   logic                   is_trap;
   dsf_pkg::dsf_kind_t     kind;
   logic                   df_ff;
   logic                   n_ff;
   logic [31:0]            q_ff;
   logic                   rv_ff;
   logic [31:0]            res_ff;
   logic [7:0]             rreg_ff;
   logic                   trap_ff;
   logic [7:0]             vec_ff;
   logic [7:0]             ipa_ff;
   logic [7:0]             ipb_ff;
   logic [7:0]             ipc_ff;
   logic [1:0]             sts_ff;
   logic [1:0]             msk_ff;
   logic                   ack_ff;
   logic [31:0]            rdata_ff;
   logic                   acc;
   logic                   wr_fire;

   assign opcode = instr_i[31:24];
   // immediate select is opcode bit 0 for both divide step forms
   assign src_b = opcode[0] ? {24'h00_0000, instr_i[7:0]} : operand_b_i;

   // add when flag clear, subtract (a + ~b + 1) when set
   assign sum = df_ff ? ({1'b0, operand_a_i} + {1'b0, ~src_b} + 33'h0_0000_0001)
                      : ({1'b0, operand_a_i} + {1'b0, src_b});
   assign nxt_df = ~(sum[32] ^ df_ff ^ n_ff);

   always_comb begin
      kind = dsf_pkg::DSF_NONE;
      vec = 8'h00;
      case (opcode)
         `DSF_OP_DIVIDE_INITIALIZE_R, `DSF_OP_DIVIDE_INITIALIZE_I: kind = dsf_pkg::DSF_INIT;
         `DSF_OP_DIV_R, `DSF_OP_DIV_I: kind = dsf_pkg::DSF_STEP;
         `DSF_OP_FP_ADD_DOUBLE: begin
            kind = dsf_pkg::DSF_TRAP;
            vec = `DSF_VEC_ADD;
         end
         `DSF_OP_FP_DIVIDE_DOUBLE: begin
            kind = dsf_pkg::DSF_TRAP;
            vec = `DSF_VEC_DIVD;
         end
         `DSF_OP_DEQ: begin
            kind = dsf_pkg::DSF_TRAP;
            vec = `DSF_VEC_EQ;
         end
         `DSF_OP_DGE: begin
            kind = dsf_pkg::DSF_TRAP;
            vec = `DSF_VEC_GE;
         end
         `DSF_OP_DGT: begin
            kind = dsf_pkg::DSF_TRAP;
            vec = `DSF_VEC_GT;
         end
         `DSF_OP_DIVIDE: begin
            kind = dsf_pkg::DSF_TRAP;
            vec = `DSF_VEC_DIVIDE;
         end
         default: kind = dsf_pkg::DSF_NONE;
      endcase
   end
   assign is_trap = issue_valid_i && (kind == dsf_pkg::DSF_TRAP);

   always_comb begin
      if (kind == dsf_pkg::DSF_INIT) begin
         shifted = {src_b[30:0], q_ff, 1'b0};
      end else begin
         shifted = {sum[30:0], q_ff, nxt_df};
      end
   end

   // never stalls: every step completes in one cycle
   assign issue_ready_o = 1'b1;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         df_ff <= 1'b0;
         n_ff <= 1'b0;
         q_ff <= `DSF_RST_WORD;
      end else if (issue_valid_i && kind == dsf_pkg::DSF_INIT) begin
         df_ff <= 1'b1;
         n_ff <= src_b[31];
         q_ff <= shifted[31:0];
      end else if (issue_valid_i && kind == dsf_pkg::DSF_STEP) begin
         df_ff <= nxt_df;
         n_ff <= sum[31];
         q_ff <= shifted[31:0];
      end else if (wr_fire && avs_address_i == `DSF_ADDR_Q && avs_byteenable_i == 4'hF) begin
         q_ff <= avs_writedata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rv_ff <= 1'b0;
         res_ff <= `DSF_RST_WORD;
         rreg_ff <= 8'h00;
      end else begin
         rv_ff <= issue_valid_i && (kind == dsf_pkg::DSF_INIT || kind == dsf_pkg::DSF_STEP);
         if (issue_valid_i && (kind == dsf_pkg::DSF_INIT || kind == dsf_pkg::DSF_STEP)) begin
            res_ff <= shifted[63:32];
            rreg_ff <= abs_rc_i;
         end
      end
   end

   // double operands and destination: pointer names the first of a twin pair
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         trap_ff <= 1'b0;
         vec_ff <= 8'h00;
         ipa_ff <= 8'h00;
         ipb_ff <= 8'h00;
         ipc_ff <= 8'h00;
      end else begin
         trap_ff <= is_trap;
         if (is_trap) begin
            vec_ff <= vec;
            ipa_ff <= abs_ra_i;
            ipb_ff <= abs_rb_i;
            ipc_ff <= abs_rc_i;
         end
      end
   end

   // bus slave: one wait cycle, then answer
   assign acc = (avs_read_i || avs_write_i) && !ack_ff;
   assign wr_fire = avs_write_i && ack_ff;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ack_ff <= 1'b0;
         rdata_ff <= `DSF_RST_WORD;
      end else begin
         ack_ff <= acc;
         case (avs_address_i)
            `DSF_ADDR_STATUS: rdata_ff <= {30'h0000_0000, sts_ff};
            `DSF_ADDR_MASK: rdata_ff <= {30'h0000_0000, msk_ff};
            `DSF_ADDR_ALU: rdata_ff <= {30'h0000_0000, df_ff, n_ff};
            `DSF_ADDR_Q: rdata_ff <= q_ff;
            default: rdata_ff <= `DSF_RST_WORD;
         endcase
      end
   end

   // sticky events, set wins over write-one-clear
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         sts_ff <= 2'b00;
         msk_ff <= 2'b00;
      end else begin
         sts_ff <= (sts_ff & ~((wr_fire && avs_address_i == `DSF_ADDR_STATUS && avs_byteenable_i[0])
                               ? avs_writedata_i[1:0] : 2'b00))
                   | {issue_valid_i && kind == dsf_pkg::DSF_STEP, is_trap};
         if (wr_fire && avs_address_i == `DSF_ADDR_MASK && avs_byteenable_i[0]) begin
            msk_ff <= avs_writedata_i[1:0];
         end
      end
   end

   assign irq_o = |(sts_ff & msk_ff);
   assign avs_readdata_o = rdata_ff;
   assign result_valid_o = rv_ff;
   assign result_o = res_ff;
   assign result_reg_o = rreg_ff;
   assign trap_o = trap_ff;
   assign trap_vector_o = vec_ff;
   assign indirect_pointer_a_o = ipa_ff;
   assign indirect_pointer_b_o = ipb_ff;
   assign indirect_pointer_c_o = ipc_ff;
   assign divide_flag_o = df_ff;
   assign negative_o = n_ff;
   assign q_o = q_ff;

   a_add_trap: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_FP_ADD_DOUBLE |=> trap_o && trap_vector_o == `DSF_VEC_ADD && !result_valid_o)
      else $error("double add did not trap");
   a_ptr_load: assert property (@(posedge clock_i) disable iff (srst_i)
      is_trap |=> indirect_pointer_a_o == $past(abs_ra_i) && indirect_pointer_c_o == $past(abs_rc_i))
      else $error("pointers not loaded on trap");
   a_div_trap: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_FP_DIVIDE_DOUBLE |=> trap_o && trap_vector_o == `DSF_VEC_DIVD)
      else $error("double divide did not trap");
   a_eq_trap: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_DEQ |=> trap_o && trap_vector_o == `DSF_VEC_EQ)
      else $error("equal compare did not trap");
   a_ge_trap: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_DGE |=> trap_o && trap_vector_o == `DSF_VEC_GE)
      else $error("greater-equal compare did not trap");
   a_gt_trap: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_DGT |=> trap_o && trap_vector_o == `DSF_VEC_GT)
      else $error("greater compare did not trap");
   a_idiv_trap: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_DIVIDE |=> trap_o && indirect_pointer_b_o == $past(abs_rb_i))
      else $error("signed divide did not trap");
   a_init_flags: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_INIT |=> divide_flag_o && negative_o == $past(src_b[31]))
      else $error("init flags wrong");
   a_step_q: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP |=> q_o[0] == divide_flag_o && q_o[31:1] == $past(q_ff[30:0]))
      else $error("step q shift wrong");
   a_one_cycle: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP ##1 issue_valid_i && kind == dsf_pkg::DSF_STEP
      |=> result_valid_o && $past(result_valid_o))
      else $error("back to back steps stalled");

   // datapath checks
   a_sub_path: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP && df_ff |-> sum[31:0] == operand_a_i - src_b)
      else $error("step with flag set did not subtract");
   a_add_path: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP && !df_ff |-> sum[31:0] == operand_a_i + src_b)
      else $error("step with flag clear did not add");
   a_imm_zero: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind != dsf_pkg::DSF_NONE && kind != dsf_pkg::DSF_TRAP && opcode[0]
      |-> src_b == {24'h00_0000, instr_i[7:0]})
      else $error("immediate operand not zero-extended");
   a_reg_operand: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP && !opcode[0] |-> src_b == operand_b_i)
      else $error("register operand not used");
   a_step_df: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP
      |=> divide_flag_o == ~($past(sum[32]) ^ $past(df_ff) ^ $past(n_ff)))
      else $error("step divide flag wrong");
   a_step_neg: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP |=> negative_o == $past(sum[31]))
      else $error("step negative flag wrong");
   a_step_res: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP |=> result_o == {$past(sum[30:0]), $past(q_ff[31])})
      else $error("step result wrong");
   a_init_res: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_INIT |=> result_o == {$past(src_b[30:0]), $past(q_ff[31])})
      else $error("init result wrong");
   a_init_q: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_INIT |=> q_o == {$past(q_ff[30:0]), 1'b0})
      else $error("init q shift wrong");
   a_ready_high: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_ready_o)
      else $error("issue stalled");
   a_rv_pulse: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && (kind == dsf_pkg::DSF_INIT || kind == dsf_pkg::DSF_STEP) |=> result_valid_o)
      else $error("step result not in one cycle");

   // trap decode checks
   a_no_result: assert property (@(posedge clock_i) disable iff (srst_i)
      is_trap |=> !result_valid_o)
      else $error("trapping opcode produced a result");
   a_no_stray: assert property (@(posedge clock_i) disable iff (srst_i)
      !is_trap |=> !trap_o)
      else $error("trap without trapping opcode");
   a_ptr_b_load: assert property (@(posedge clock_i) disable iff (srst_i)
      is_trap |=> indirect_pointer_b_o == $past(abs_rb_i))
      else $error("pointer b not loaded on trap");
   a_ptr_hold: assert property (@(posedge clock_i) disable iff (srst_i)
      !is_trap |=> $stable(indirect_pointer_a_o) && $stable(indirect_pointer_b_o)
      && $stable(indirect_pointer_c_o))
      else $error("pointers changed without trap");
   a_idiv_vec: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_DIVIDE
      |=> trap_vector_o == `DSF_VEC_DIVIDE && indirect_pointer_a_o == $past(abs_ra_i))
      else $error("signed divide vector or pointer wrong");

   // bus and event checks
   a_bus_answer: assert property (@(posedge clock_i) disable iff (srst_i)
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus wait longer than one cycle");
   a_q_write: assert property (@(posedge clock_i) disable iff (srst_i)
      wr_fire && avs_address_i == `DSF_ADDR_Q && avs_byteenable_i == 4'hF && !issue_valid_i
      |=> q_o == $past(avs_writedata_i))
      else $error("q write lost");
   a_trap_event: assert property (@(posedge clock_i) disable iff (srst_i)
      is_trap |=> sts_ff[`DSF_IRQ_TRAP])
      else $error("trap event not recorded");
   a_step_event: assert property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_STEP |=> sts_ff[`DSF_IRQ_STEP])
      else $error("step event not recorded");

   c_step_pair: cover property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && kind == dsf_pkg::DSF_INIT ##1 issue_valid_i && kind == dsf_pkg::DSF_STEP);
   c_trap: cover property (@(posedge clock_i) disable iff (srst_i) trap_o);
   c_irq: cover property (@(posedge clock_i) disable iff (srst_i) irq_o);
   c_bus_write: cover property (@(posedge clock_i) disable iff (srst_i) wr_fire);
   c_idiv: cover property (@(posedge clock_i) disable iff (srst_i)
      issue_valid_i && opcode == `DSF_OP_DIVIDE);
endmodule : dsf_core
`default_nettype wire

// ===== inc/dsf_regs.svh
// constants of the divide step and fp trap decode block
// included by the design file by bare name; the bench uses literal values
`ifndef DSF_REGS_SVH
`define DSF_REGS_SVH
// opcodes
`define DSF_OP_DIVIDE_INITIALIZE_R      8'h68
`define DSF_OP_DIVIDE_INITIALIZE_I      8'h69
`define DSF_OP_DIV_R       8'h6A
`define DSF_OP_DIV_I       8'h6B
`define DSF_OP_DIVIDE      8'hE1
`define DSF_OP_DEQ         8'hEB
`define DSF_OP_DGT         8'hED
`define DSF_OP_DGE         8'hEF
`define DSF_OP_FP_ADD_DOUBLE        8'hF1
`define DSF_OP_FP_DIVIDE_DOUBLE        8'hF7
// trap vector numbers
`define DSF_VEC_DIVIDE     8'h1A
`define DSF_VEC_EQ         8'h1B
`define DSF_VEC_GT         8'h1C
`define DSF_VEC_GE         8'h1D
`define DSF_VEC_ADD        8'h1E
`define DSF_VEC_DIVD       8'h1F
// avalon register offsets (byte addresses)
`define DSF_ADDR_STATUS    4'h0
`define DSF_ADDR_MASK      4'h4
`define DSF_ADDR_ALU       4'h8
`define DSF_ADDR_Q         4'hC
// status bits
`define DSF_IRQ_TRAP       0
`define DSF_IRQ_STEP       1
// alu flag positions in the alu register
`define DSF_ALU_N          0
`define DSF_ALU_DF         1
`define DSF_RST_WORD       32'h0000_0000
`endif

// ===== inc/dsf_pkg.sv
// types of the divide step and fp trap decode block
// no assumptions
package dsf_pkg;
   typedef enum logic [2:0] {
      DSF_NONE,
      DSF_INIT,
      DSF_STEP,
      DSF_TRAP
   } dsf_kind_t;
endpackage : dsf_pkg

// ===== verification/dsf_trap_model.sv
// partner model: trap unit entered by the execute stage
// assumes one clock, sync reset, trap pulses that last one cycle
`timescale 1ns/1ns
`default_nettype none
module dsf_trap_model (
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic       trap_i,
   input  wire logic [7:0] vector_i,
   output logic [7:0]      entries_o,
   output logic [7:0]      last_vector_o
);
   // counts handler entries; rounding, compare results and fp flags are the handler's job
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         entries_o     <= 8'h00;
         last_vector_o <= 8'h00;
      end else if (trap_i) begin
         entries_o     <= entries_o + 8'h01;
         last_vector_o <= vector_i;
      end
   end
endmodule : dsf_trap_model
`default_nettype wire

// ===== verification/tb_divide_step_and_fp_trap_decode.sv
// testbench: divide init/step datapath, fp trap decode, register bus
// assumes dsf_core as device, trap unit model on the far side
`timescale 1ns/1ns
`default_nettype none
module tb_divide_step_and_fp_trap_decode;
   logic        clock_i, srst_i, issue_valid_i, avs_read_i, avs_write_i;
   logic        issue_ready_o, result_valid_o, trap_o, divide_flag_o, negative_o, avs_waitrequest_o, irq_o;
   logic        m_df, m_n, p_rv, p_tr;
   logic [31:0] instr_i, operand_a_i, operand_b_i, avs_writedata_i, result_o, q_o, avs_readdata_o;
   logic [31:0] rd, p_res, m_q;
   logic [7:0]  abs_ra_i, abs_rb_i, abs_rc_i, result_reg_o, trap_vector_o, indirect_pointer_a, indirect_pointer_b, indirect_pointer_c, ents, lvec;
   logic [7:0]  m_vec, m_pa, m_pb, m_pc, p_rc;
   logic [3:0]  avs_address_i, avs_byteenable_i;
   logic [7:0]  top[6]  = '{8'hF1, 8'hF7, 8'hEB, 8'hEF, 8'hED, 8'hE1};
   logic [7:0]  tvec[6] = '{8'h1E, 8'h1F, 8'h1B, 8'h1D, 8'h1C, 8'h1A};
   int          bad_count, checks_done;

   dsf_core dut (.clock_i(clock_i), .srst_i(srst_i), .issue_valid_i(issue_valid_i), .instr_i(instr_i),
      .operand_a_i(operand_a_i), .operand_b_i(operand_b_i), .abs_ra_i(abs_ra_i), .abs_rb_i(abs_rb_i),
      .abs_rc_i(abs_rc_i), .issue_ready_o(issue_ready_o), .result_valid_o(result_valid_o),
      .result_o(result_o), .result_reg_o(result_reg_o), .trap_o(trap_o), .trap_vector_o(trap_vector_o),
      .indirect_pointer_a_o(indirect_pointer_a), .indirect_pointer_b_o(indirect_pointer_b), .indirect_pointer_c_o(indirect_pointer_c),
      .divide_flag_o(divide_flag_o), .negative_o(negative_o), .q_o(q_o), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
   dsf_trap_model far (.clock_i(clock_i), .srst_i(srst_i), .trap_i(trap_o), .vector_i(trap_vector_o),
      .entries_o(ents), .last_vector_o(lvec));

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clock_i);
      avs_read_i <= !w; avs_write_i <= w; avs_address_i <= a; avs_writedata_i <= d; avs_byteenable_i <= be;
      do begin
         @(negedge clock_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 50);
      if (n >= 50) chk("waitrequest", avs_waitrequest_o, 32'h0);
      rd = avs_readdata_o;
      @(posedge clock_i);
      avs_read_i <= 1'b0; avs_write_i <= 1'b0;
   endtask : av

   // drives one issue, checks the answer to the previous one, then predicts this one
   task automatic iss(input logic v, input logic [7:0] op, input logic [31:0] a, input logic [31:0] b,
                      input logic [7:0] imm);
      logic [31:0] bb;
      logic [32:0] s;
      logic        nd;
      @(posedge clock_i);
      issue_valid_i <= v; instr_i <= {op, 16'h0000, imm}; operand_a_i <= a; operand_b_i <= b;
      abs_ra_i <= op ^ 8'h11; abs_rb_i <= op ^ 8'h22; abs_rc_i <= op ^ 8'h44;
      @(negedge clock_i);
      chk("result_valid", result_valid_o, p_rv);
      chk("trap", trap_o, p_tr);
      if (p_rv) chk("result", result_o, p_res);
      if (p_rv) chk("result_reg", result_reg_o, p_rc);
      chk("q", q_o, m_q);
      chk("flags", {divide_flag_o, negative_o}, {m_df, m_n});
      chk("vector", trap_vector_o, m_vec);
      chk("pointers", {indirect_pointer_a, indirect_pointer_b, indirect_pointer_c}, {m_pa, m_pb, m_pc});
      p_rv = 1'b0; p_tr = 1'b0; p_rc = op ^ 8'h44;
      bb = op[0] ? {24'h000000, imm} : b;
      if (v && op[7:1] == 7'h34) begin
         p_rv = 1'b1; p_res = {bb[30:0], m_q[31]}; m_q = {m_q[30:0], 1'b0}; m_df = 1'b1; m_n = bb[31];
      end
      if (v && op[7:1] == 7'h35) begin
         s = m_df ? {1'b0, a} + {1'b0, ~bb} + 33'h1 : {1'b0, a} + {1'b0, bb};
         nd = ~(s[32] ^ m_df ^ m_n);
         p_rv = 1'b1; p_res = {s[30:0], m_q[31]}; m_q = {m_q[30:0], nd}; m_df = nd; m_n = s[31];
      end
      for (int i = 0; i < 6; i++) if (v && op == top[i]) begin
         p_tr = 1'b1; m_vec = tvec[i]; m_pa = op ^ 8'h11; m_pb = op ^ 8'h22; m_pc = op ^ 8'h44;
      end
   endtask : iss

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   initial begin
      #20000;
      bad_count++;
      final_report();
   end

   initial begin
      srst_i = 1'b1; issue_valid_i = 1'b0; instr_i = 32'h0; operand_a_i = 32'h0; operand_b_i = 32'h0;
      abs_ra_i = 8'h00; abs_rb_i = 8'h00; abs_rc_i = 8'h00; avs_read_i = 1'b0; avs_write_i = 1'b0;
      avs_address_i = 4'h0; avs_writedata_i = 32'h0; avs_byteenable_i = 4'hF;
      m_q = 32'h0; m_df = 1'b0; m_n = 1'b0; p_rv = 1'b0; p_tr = 1'b0; p_res = 32'h0;
      m_vec = 8'h00; m_pa = 8'h00; m_pb = 8'h00; m_pc = 8'h00; p_rc = 8'h00;
      repeat (3) @(posedge clock_i);
      srst_i <= 1'b0;
      @(negedge clock_i);
      chk("ready", issue_ready_o, 32'h1);
      av(1'b1, 4'hC, 32'h8765_4321, 4'hF);
      m_q = 32'h8765_4321;
      av(1'b1, 4'hC, 32'h0000_0000, 4'h3);
      av(1'b0, 4'hC, 32'h0, 4'hF);
      chk("q_read", rd, m_q);
      $display("test bus_q done");
      iss(1'b1, 8'h68, 32'h0, 32'h0000_1234, 8'h00);
      repeat (32) iss(1'b1, 8'h6A, p_res, 32'h0000_1234, 8'h00);
      iss(1'b1, 8'h69, 32'h0, 32'hFFFF_FFFF, 8'hA5);
      iss(1'b1, 8'h6B, p_res, 32'hFFFF_FFFF, 8'h81);
      iss(1'b1, 8'h6A, p_res, 32'h8000_0001, 8'h00);
      $display("test divide_steps done");
      for (int i = 0; i < 6; i++) iss(1'b1, top[i], 32'h1111_2222, 32'h3333_4444, 8'h00);
      iss(1'b1, 8'h00, 32'h0, 32'h0, 8'h00);
      iss(1'b0, 8'h00, 32'h0, 32'h0, 8'h00);
      chk("trap_entries", {ents, lvec}, {8'h06, 8'h1A});
      $display("test traps done");
      av(1'b0, 4'h8, 32'h0, 4'hF);
      chk("alu_read", rd, {30'h0, m_df, m_n});
      av(1'b0, 4'h1, 32'h0, 4'hF);
      chk("unmapped", rd, 32'h0);
      av(1'b0, 4'h0, 32'h0, 4'hF);
      chk("status", rd, 32'h3);
      chk("irq_masked", irq_o, 32'h0);
      av(1'b1, 4'h4, 32'h1, 4'hF);
      @(negedge clock_i);
      chk("irq_trap", irq_o, 32'h1);
      av(1'b1, 4'h0, 32'h1, 4'hF);
      av(1'b1, 4'h4, 32'h2, 4'hF);
      @(negedge clock_i);
      chk("irq_step", irq_o, 32'h1);
      av(1'b1, 4'h0, 32'h2, 4'hF);
      @(negedge clock_i);
      chk("irq_clear", irq_o, 32'h0);
      av(1'b0, 4'h0, 32'h0, 4'hF);
      chk("status_clear", rd, 32'h0);
      $display("test interrupts done");
      final_report();
   end
endmodule : tb_divide_step_and_fp_trap_decode
`default_nettype wire
